/* seb_eeprom_slave.sv */
// Summary of operation
// - Data falling while clock high is a Start; control-byte reception restarts.
// - Data rising while clock high is a Stop; the current operation ends.
// - Data changes only while clock low; one bit per clock pulse.
// - Addressed receiver acknowledges each byte on the ninth clock pulse.
// - No acknowledge at all while the internal write cycle runs.
// - Acknowledge holds data low through the whole ninth clock high period.
// - Master ends a read with no acknowledge; device then releases data.
// - First byte after Start: code 1010, three select bits, read/write bit.
// - Respond only when select bits match the three select pins.
// - Read/write bit one selects read, zero selects write.
// - Write: acknowledge control byte, load next byte into address pointer.
// - Stop after an acknowledged data byte launches the self-timed write.
// - Protected writes are acknowledged but leave the memory unchanged.
// - Protected writes still take the full write cycle time.
// - Page buffer takes up to sixteen bytes, committed only after Stop.
// - Each write byte increments only the low four pointer bits.
// - Beyond sixteen bytes the pointer wraps; only the last sixteen remain.
// - Protect input high blocks writes to 80h-FFh; low allows all.
// - Sequential reads wrap inside this device, never into a neighbour.
// - Data is only pulled low or released, never driven high.

`include "seb_defs.svh"

`default_nettype none

module seb_eeprom_slave #(
	parameter int unsigned TWC_CYCLES = `SEB_TWC_MS * `SEB_REF_HZ / `SEB_MS_PER_S
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic chip_select_bit0_pin,
	input wire logic chip_select_bit1_pin,
	input wire logic chip_select_bit2_pin,
	input wire logic write_protect_pin,
	output logic sda_out,
	output logic sda_oe,
	output logic write_busy
);

	// ------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------
	// The write cycle counter is sixteen bits wide.
	localparam int unsigned TWC_MAX = 32'h0000_FFFF;

	generate
		if (TWC_CYCLES < 1 || TWC_CYCLES > TWC_MAX) begin : g_bad_twc
			$error("TWC_CYCLES must lie between 1 and 65535");
		end
	endgenerate

	localparam logic [15:0] TWC_LAST = 16'(TWC_CYCLES - 1);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	seb_pkg::seb_link_t l_r;
	seb_pkg::seb_link_t l_nxt;
	seb_pkg::seb_ref_t r_r;
	seb_pkg::seb_ref_t r_nxt;
	logic start_tog_r;
	logic stop_tog_r;
	logic rise_sda_r;
	logic ev_start;
	logic ev_stop;
	logic [7:0] byte_in;
	logic [7:0] mem_rd;
	logic ack_ok;
	logic mem_we;
	logic [7:0] mem_wa;
	logic [7:0] mem_wd;
	logic [7:0] mem [0:255];

	// ------------------------------------------------------------------
	// Start and Stop detection
	// ------------------------------------------------------------------
	// Start and Stop happen while the serial clock is high, so no clock
	// edge sees them; the data line itself clocks these two toggles.
	always_ff @(negedge sda_in or posedge reset) begin
		if (reset) begin
			start_tog_r <= 1'b0;
		end else if (scl_in) begin
			start_tog_r <= ~start_tog_r;
		end
	end

	always_ff @(posedge sda_in or posedge reset) begin
		if (reset) begin
			stop_tog_r <= 1'b0;
		end else if (scl_in) begin
			stop_tog_r <= ~stop_tog_r;
		end
	end

	// The data line is sampled on the rising clock edge, at the start of
	// the stable high period, and consumed at the following falling edge.
	always_ff @(posedge scl_in or posedge reset) begin
		if (reset) begin
			rise_sda_r <= 1'b1;
		end else begin
			rise_sda_r <= sda_in;
		end
	end

	// The toggles are read directly at the falling clock edge: the bus hold
	// times guarantee that a toggle has settled well before that edge.
	assign ev_start = start_tog_r ^ l_r.start_seen;
	assign ev_stop = stop_tog_r ^ l_r.stop_seen;
	assign byte_in = {l_r.shreg[6:0], rise_sda_r};

	// Control bytes are only matched while no write cycle runs.
	assign ack_ok = !l_r.busy_s[1] && (l_r.state != seb_pkg::ls_ctrl ||
		(byte_in[7:4] == `SEB_CTRL_CODE && byte_in[3:1] == l_r.cs_s[1]));

	// Reads see the array while no commit runs: a commit only starts after
	// a Stop, and the link acknowledges nothing until it ends.
	assign mem_rd = mem[l_r.ptr];

	// ------------------------------------------------------------------
	// Link state machine, advanced on the falling serial clock edge
	// ------------------------------------------------------------------
	always_comb begin
		l_nxt = l_r;
		l_nxt.busy_s = {l_r.busy_s[0], r_r.busy};
		l_nxt.cs_s = {l_r.cs_s[0],
			{chip_select_bit2_pin, chip_select_bit1_pin, chip_select_bit0_pin}};
		if (ev_start) begin
			// A Start wins over a Stop seen in the same clock high period.
			l_nxt.start_seen = start_tog_r;
			l_nxt.stop_seen = stop_tog_r;
			l_nxt.state = seb_pkg::ls_ctrl;
			l_nxt.cnt = 4'h0;
			l_nxt.oe = 1'b0;
			l_nxt.armed = 1'b0;
		end else if (ev_stop) begin
			l_nxt.stop_seen = stop_tog_r;
			l_nxt.state = seb_pkg::ls_idle;
			l_nxt.cnt = 4'h0;
			l_nxt.oe = 1'b0;
		end else begin
			case (l_r.state)
				seb_pkg::ls_idle: begin
					l_nxt.oe = 1'b0;
				end
				// Bit seven leaves at the fall that ends the acknowledge slot, bits
				// six to zero at the next seven falls; the eighth fall then frees
				// the line so that the master can answer in the ninth pulse.
				seb_pkg::ls_rdata: begin
					if (l_r.cnt < `SEB_LAST_BIT) begin
						// Next bit goes out while the clock is low.
						l_nxt.shreg = {l_r.shreg[6:0], 1'b0};
						l_nxt.oe = ~l_r.shreg[6];
						l_nxt.cnt = l_r.cnt + 4'h1;
					end else if (l_r.cnt == `SEB_LAST_BIT) begin
						l_nxt.oe = 1'b0;
						l_nxt.cnt = `SEB_ACK_SLOT;
						l_nxt.ptr = l_r.ptr + 8'h01;
					end else if (rise_sda_r) begin
						l_nxt.state = seb_pkg::ls_idle;
						l_nxt.oe = 1'b0;
						l_nxt.cnt = 4'h0;
					end else begin
						l_nxt.shreg = mem_rd;
						l_nxt.oe = ~mem_rd[7];
						l_nxt.cnt = 4'h0;
					end
				end
				default: begin
					if (l_r.cnt < `SEB_LAST_BIT) begin
						l_nxt.shreg = byte_in;
						l_nxt.cnt = l_r.cnt + 4'h1;
					end else if (l_r.cnt == `SEB_LAST_BIT) begin
						l_nxt.shreg = byte_in;
						l_nxt.cnt = `SEB_ACK_SLOT;
						if (ack_ok) begin
							// Pull low for the whole ninth clock pulse.
							l_nxt.oe = 1'b1;
							case (l_r.state)
								seb_pkg::ls_ctrl: begin
									l_nxt.rw = byte_in[0];
								end
								seb_pkg::ls_addr: begin
									l_nxt.ptr = byte_in;
									l_nxt.vld = 16'h0000;
								end
								default: begin
									l_nxt.pagebuf[l_r.ptr[3:0]] = byte_in;
									l_nxt.vld[l_r.ptr[3:0]] = 1'b1;
									l_nxt.ptr = {l_r.ptr[7:4], l_r.ptr[3:0] + 4'h1};
									l_nxt.armed = 1'b1;
								end
							endcase
						end else begin
							// Not addressed, or busy: stay off the bus until Start.
							l_nxt.state = seb_pkg::ls_idle;
						end
					end else begin
						l_nxt.oe = 1'b0;
						l_nxt.cnt = 4'h0;
						case (l_r.state)
							seb_pkg::ls_ctrl: begin
								if (l_r.rw) begin
									l_nxt.state = seb_pkg::ls_rdata;
									l_nxt.shreg = mem_rd;
									l_nxt.oe = ~mem_rd[7];
								end else begin
									l_nxt.state = seb_pkg::ls_addr;
								end
							end
							default: begin
								l_nxt.state = seb_pkg::ls_wdata;
							end
						endcase
					end
				end
			endcase
		end
	end

	always_ff @(negedge scl_in or posedge reset) begin
		if (reset) begin
			l_r <= '0;
		end else begin
			l_r <= l_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Write engine, on the reference clock
	// ------------------------------------------------------------------
	// The page buffer is read across the domain boundary only after a
	// Stop, when the serial clock stands still and nothing may change it.
	assign mem_wa = {l_r.ptr[7:4], r_r.idx};
	assign mem_wd = l_r.pagebuf[r_r.idx];
	assign mem_we = (r_r.state == seb_pkg::ws_copy) && l_r.vld[r_r.idx] &&
		!(r_r.wp_s[1] && mem_wa[7]);

	always_comb begin
		r_nxt = r_r;
		r_nxt.stop_s = {r_r.stop_s[1:0], stop_tog_r};
		r_nxt.armed_s = {r_r.armed_s[0], l_r.armed};
		r_nxt.wp_s = {r_r.wp_s[0], write_protect_pin};
		r_nxt.sda_out = 1'b0;
		case (r_r.state)
			seb_pkg::ws_idle: begin
				if ((r_r.stop_s[2] ^ r_r.stop_s[1]) && r_r.armed_s[1]) begin
					r_nxt.state = seb_pkg::ws_copy;
					r_nxt.idx = 4'h0;
					r_nxt.busy = 1'b1;
				end
			end
			seb_pkg::ws_copy: begin
				r_nxt.idx = r_r.idx + 4'h1;
				if (r_r.idx == `SEB_PAGE_LAST) begin
					r_nxt.state = seb_pkg::ws_wait;
					r_nxt.cnt = 16'h0000;
				end
			end
			default: begin
				// The full wait runs even when every byte was protected.
				if (r_r.cnt == TWC_LAST) begin
					r_nxt.state = seb_pkg::ws_idle;
					r_nxt.busy = 1'b0;
				end else begin
					r_nxt.cnt = r_r.cnt + 16'h0001;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			r_r <= '0;
		end else begin
			r_r <= r_nxt;
		end
	end

	// The array has no reset; its content after power-up is undefined.
	always_ff @(posedge ref_clk) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign sda_out = r_r.sda_out;
	assign sda_oe = l_r.oe;
	assign write_busy = r_r.busy;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	a_start_restart: assert property (@(negedge scl_in) disable iff (reset)
		ev_start |=> l_r.state == seb_pkg::ls_ctrl && l_r.cnt == 4'h0 && !l_r.oe)
		else $error("Start did not restart control byte reception");

	a_stop_ends: assert property (@(negedge scl_in) disable iff (reset)
		(ev_stop && !ev_start) |=> l_r.state == seb_pkg::ls_idle && !l_r.oe)
		else $error("Stop did not end the operation");

	a_busy_no_ack: assert property (@(negedge scl_in) disable iff (reset)
		(l_r.busy_s[1] && l_r.cnt == `SEB_LAST_BIT && !ev_start && !ev_stop &&
		l_r.state != seb_pkg::ls_rdata && l_r.state != seb_pkg::ls_idle) |=> !l_r.oe)
		else $error("Acknowledge given during a write cycle");

	a_ctrl_match: assert property (@(negedge scl_in) disable iff (reset)
		(l_r.state == seb_pkg::ls_ctrl && l_r.cnt == `SEB_LAST_BIT && !ev_start &&
		!ev_stop && !l_r.busy_s[1]) |=> l_r.oe == ($past(byte_in[7:4]) ==
		`SEB_CTRL_CODE && $past(byte_in[3:1]) == $past(l_r.cs_s[1])))
		else $error("Control byte acknowledge disagrees with code and select pins");

	a_ack_one_pulse: assert property (@(negedge scl_in) disable iff (reset)
		(l_r.oe && l_r.cnt == `SEB_ACK_SLOT && l_r.state == seb_pkg::ls_addr) |=>
		!l_r.oe && l_r.state == seb_pkg::ls_wdata)
		else $error("Address acknowledge not released after the ninth pulse");

	a_page_wrap: assert property (@(negedge scl_in) disable iff (reset)
		(l_r.state == seb_pkg::ls_wdata && l_r.cnt == `SEB_LAST_BIT && !ev_start &&
		!ev_stop && ack_ok) |=> l_r.ptr[7:4] == $past(l_r.ptr[7:4]) &&
		l_r.ptr[3:0] == $past(l_r.ptr[3:0]) + 4'h1 && l_r.armed)
		else $error("Write pointer left its page or did not advance");

	a_read_nack: assert property (@(negedge scl_in) disable iff (reset)
		(l_r.state == seb_pkg::ls_rdata && l_r.cnt == `SEB_ACK_SLOT && rise_sda_r &&
		!ev_start && !ev_stop) |=> l_r.state == seb_pkg::ls_idle && !l_r.oe)
		else $error("Data line not released after master nack");

	a_seq_wrap: assert property (@(negedge scl_in) disable iff (reset)
		(l_r.state == seb_pkg::ls_rdata && l_r.cnt == `SEB_LAST_BIT &&
		!ev_start && !ev_stop) |=> l_r.ptr == $past(l_r.ptr) + 8'h01 && !l_r.oe)
		else $error("Read pointer did not advance by one within the device");

	a_protect: assert property (@(posedge ref_clk) disable iff (reset)
		(r_r.wp_s[1] && l_r.ptr[7]) |-> !mem_we)
		else $error("Write reached the protected upper half");

	a_cycle_hold: assert property (@(posedge ref_clk) disable iff (reset)
		$rose(r_r.busy) |-> (r_r.state == seb_pkg::ws_copy)[*8] ##1
		(r_r.state == seb_pkg::ws_copy)[*8] ##1 r_r.state == seb_pkg::ws_wait && r_r.busy)
		else $error("Write cycle shortened");

	a_addr_load: assert property (@(negedge scl_in) disable iff (reset)
		(l_r.state == seb_pkg::ls_addr && l_r.cnt == `SEB_LAST_BIT && !ev_start &&
		!ev_stop && ack_ok) |=> l_r.ptr == $past(byte_in) && l_r.oe)
		else $error("Address byte not loaded into the pointer");

	a_read_select: assert property (@(negedge scl_in) disable iff (reset)
		(l_r.state == seb_pkg::ls_ctrl && l_r.cnt == `SEB_ACK_SLOT && !ev_start &&
		!ev_stop) |=> l_r.state == (l_r.rw ? seb_pkg::ls_rdata : seb_pkg::ls_addr))
		else $error("Read or write not selected by the last control bit");

	a_idle_silent: assert property (@(negedge scl_in) disable iff (reset)
		l_r.state == seb_pkg::ls_idle |-> !l_r.oe)
		else $error("Data line pulled while not addressed");

	a_commit_on_stop: assert property (@(posedge ref_clk) disable iff (reset)
		(r_r.state == seb_pkg::ws_idle && r_r.stop_s[2] == r_r.stop_s[1]) |=> !r_r.busy)
		else $error("Write cycle began without a Stop");

	a_wait_full: assert property (@(posedge ref_clk) disable iff (reset)
		(r_r.state == seb_pkg::ws_wait && r_r.cnt != TWC_LAST) |=>
		r_r.state == seb_pkg::ws_wait && r_r.busy)
		else $error("Write cycle wait ended early");

endmodule : seb_eeprom_slave

`default_nettype wire

/* seb_defs.svh */
`ifndef SEB_DEFS_SVH
`define SEB_DEFS_SVH

// ----------------------------------------------------------------------
// Control byte and bit counting
// ----------------------------------------------------------------------
// Four-bit code that the top of a control byte must carry.
`define SEB_CTRL_CODE 4'hA
// Bit count at which the eighth bit of a byte has been sampled.
`define SEB_LAST_BIT 4'h7
// Bit count of the acknowledge slot, the ninth clock pulse.
`define SEB_ACK_SLOT 4'h8
// Last entry of the sixteen-byte page buffer.
`define SEB_PAGE_LAST 4'hF

// ----------------------------------------------------------------------
// Write cycle timing
// ----------------------------------------------------------------------
// Self-timed write cycle, in milliseconds.
`define SEB_TWC_MS 32'h0000_0005
// Reference clock rate, in hertz.
`define SEB_REF_HZ 32'h0098_9680
// Milliseconds per second.
`define SEB_MS_PER_S 32'h0000_03E8

`endif

/* seb_pkg.sv */
`default_nettype none

package seb_pkg;

	// ------------------------------------------------------------------
	// Link side state, clocked by the falling edge of the serial clock
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {ls_idle, ls_ctrl, ls_addr, ls_wdata, ls_rdata} seb_lstate_t;

	typedef struct packed {
		seb_lstate_t state;
		logic [3:0] cnt;
		logic [7:0] shreg;
		logic oe;
		logic rw;
		logic armed;
		logic [7:0] ptr;
		logic [15:0][7:0] pagebuf;
		logic [15:0] vld;
		logic start_seen;
		logic stop_seen;
		logic [1:0] busy_s;
		logic [1:0][2:0] cs_s;
	} seb_link_t;

	// ------------------------------------------------------------------
	// Write engine state, clocked by the reference clock
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {ws_idle, ws_copy, ws_wait} seb_wstate_t;

	typedef struct packed {
		seb_wstate_t state;
		logic [2:0] stop_s;
		logic [1:0] armed_s;
		logic [1:0] wp_s;
		logic [3:0] idx;
		logic [15:0] cnt;
		logic busy;
		logic sda_out;
	} seb_ref_t;

endpackage : seb_pkg

`default_nettype wire

/* seb_bus_master.sv */
`default_nettype none

// ----------------------------------------------------------------------
// Two-wire bus master model
// ----------------------------------------------------------------------
module seb_bus_master (
	output var logic scl,
	output var logic sda_pull,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 1ns;

	// Both lines rest released, so the pull-up shows an idle bus between frames.
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	// A Start from idle, or a repeated Start raised from a low clock.
	task automatic start();
		if (!scl) begin
			sda_pull = 1'b0;
			#40 scl = 1'b1;
			#40;
		end
		sda_pull = 1'b1;
		#40 scl = 1'b0;
	endtask : start

	// One bit; data moves only in the low half, and the line is read at both ends of the high half.
	task automatic bit_io(input logic b, output logic r);
		#40 sda_pull = !b;
		#40 scl = 1'b1;
		r = sda;
		#80 r = r | sda;
		scl = 1'b0;
	endtask : bit_io

	// Data rises while the clock is high and the bus is left idle.
	task automatic stop();
		#40 sda_pull = 1'b1;
		#40 scl = 1'b1;
		#40 sda_pull = 1'b0;
		#40;
	endtask : stop

	// Sends a byte most significant bit first and reads the acknowledge slot.
	task automatic send(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask : send

	// Reads a byte; the last byte of a read is not acknowledged.
	task automatic recv(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask : recv
endmodule : seb_bus_master

`default_nettype wire

/* tb_seb_eeprom_slave.sv */
`default_nettype none

// ----------------------------------------------------------------------
// Bench for the serial memory slave
// ----------------------------------------------------------------------
module tb_seb_eeprom_slave;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int twc = 20;
	localparam logic [7:0] ctrl_w = 8'hAA;
	logic ref_clk, reset, cs0, cs1, cs2, wp, scl, m_pull, sda, sda_out, sda_oe, write_busy;
	int num_errors, checks_done;

	// Open-drain wire with a pull-up: anyone pulling wins.
	assign sda = (m_pull | sda_oe) ? 1'b0 : 1'b1;

	seb_eeprom_slave #(.TWC_CYCLES(twc)) dut_u (.ref_clk(ref_clk), .reset(reset),
		.scl_in(scl), .sda_in(sda), .chip_select_bit0_pin(cs0), .chip_select_bit1_pin(cs1),
		.chip_select_bit2_pin(cs2), .write_protect_pin(wp), .sda_out(sda_out),
		.sda_oe(sda_oe), .write_busy(write_busy));
	seb_bus_master bm_u (.scl(scl), .sda_pull(m_pull), .sda(sda));

	// Reference clock; the link clock comes from the master model, in frames and in one bare pulse after a Stop.
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic finish_test();
		if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : finish_test

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Counts cycles until write_busy shows a level; a hang ends the run.
	task automatic wait_busy(input logic lvl, output int n);
		n = 0;
		while (write_busy !== lvl) begin
			@(negedge ref_clk);
			n++;
			if (n > 200) begin
				num_errors++;
				finish_test();
			end
		end
	endtask : wait_busy

	// A commit must start promptly and last the copy plus the timed wait.
	task automatic busy_len();
		int n;
		wait_busy(1'b1, n);
		check("busy start", 8'(n <= 5), 8'h01);
		wait_busy(1'b0, n);
		check("busy length", 8'(n), 8'(16 + twc));
	endtask : busy_len

	task automatic open(input logic [7:0] ctrl, output logic ack);
		bm_u.start();
		bm_u.send(ctrl, ack);
	endtask : open

	task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
		logic ack;
		open(ctrl_w, ack);
		check("ctrl ack", {7'h0, ack}, 8'h01);
		bm_u.send(a, ack);
		check("addr ack", {7'h0, ack}, 8'h01);
		foreach (d[i]) begin
			bm_u.send(d[i], ack);
			check("data ack", {7'h0, ack}, 8'h01);
		end
		bm_u.stop();
	endtask : wr

	// Random read: pointer set by a write header, then a repeated Start with read selected.
	task automatic rd(input logic [7:0] a, input logic [7:0] exp[$]);
		logic ack;
		logic [7:0] d;
		open(ctrl_w, ack);
		bm_u.send(a, ack);
		open(ctrl_w | 8'h01, ack);
		check("read ack", {7'h0, ack}, 8'h01);
		foreach (exp[i]) begin
			bm_u.recv(i == exp.size() - 1, d);
			check("read data", d, exp[i]);
		end
		check("sda out", {7'h0, sda_out}, 8'h00);
		bm_u.stop();
	endtask : rd

	// Wrong code and wrong select bits are both ignored.
	task automatic s_reject();
		logic ack;
		logic [7:0] bad[2] = '{8'hBA, 8'hA8};
		foreach (bad[i]) begin
			open(bad[i], ack);
			check("reject ack", {7'h0, ack}, 8'h00);
			bm_u.stop();
		end
	endtask : s_reject

	// A Start after four bits restarts reception; a header without data commits nothing.
	task automatic s_abort();
		logic r;
		int n;
		bm_u.start();
		for (int i = 0; i < 4; i++) bm_u.bit_io(1'b1, r);
		open(ctrl_w, r);
		check("restart ack", {7'h0, r}, 8'h01);
		bm_u.send(8'h20, r);
		bm_u.stop();
		// A bare clock fall after the Stop must find the device idle and silent.
		bm_u.bit_io(1'b1, r);
		check("stop release", {7'h0, r}, 8'h01);
		for (n = 0; n < 10; n++) @(negedge ref_clk);
		check("no commit", {7'h0, write_busy}, 8'h00);
	endtask : s_abort

	// The upper half is protected only while the protect input is high.
	task automatic s_protect();
		wr(8'h85, '{8'h5A});
		busy_len();
		@(posedge ref_clk) wp <= 1'b1;
		wr(8'h85, '{8'hA5});
		busy_len();
		wr(8'h05, '{8'h3C});
		busy_len();
		rd(8'h85, '{8'h5A});
		rd(8'h05, '{8'h3C});
		@(posedge ref_clk) wp <= 1'b0;
	endtask : s_protect

	// Seventeen bytes from 13h wrap in the page; the last one replaces the first.
	task automatic s_page();
		logic [7:0] d[$];
		logic [7:0] exp[$];
		logic ack;
		int n;
		for (int j = 0; j < 17; j++) d.push_back(8'h40 + 8'(j));
		for (int k = 0; k < 16; k++) exp.push_back(8'h40 + 8'((k + 13) % 16 == 0 ? 16 : (k + 13) % 16));
		wr(8'h13, d);
		wait_busy(1'b1, n);
		open(ctrl_w, ack);
		check("busy ack", {7'h0, ack}, 8'h00);
		bm_u.stop();
		wait_busy(1'b0, n);
		rd(8'h10, exp);
	endtask : s_page

	// Reset, then every scenario in turn.
	initial begin
		num_errors = 0;
		checks_done = 0;
		// Non-blocking so that every reset process is already waiting for the edge.
		reset <= 1'b1;
		wp <= 1'b0;
		cs0 <= 1'b1;
		cs1 <= 1'b0;
		cs2 <= 1'b1;
		repeat (4) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		#13;
		check("idle oe", {7'h0, sda_oe}, 8'h00);
		s_reject();
		s_abort();
		s_protect();
		s_page();
		finish_test();
	end
endmodule : tb_seb_eeprom_slave

`default_nettype wire
